// ### hw/trm_top.sv
// thermal relays, maintenance channels and engine link supervision
`timescale 1ns/10ps
// Contract
// RULE_01: cooler relay turns on when coolant is above cooler-on, default 90.
// RULE_02: cooler relay turns off when coolant is below cooler-off, default 80.
// RULE_03: heater relay turns on when coolant is below heater-on, default 50.
// RULE_04: heater relay turns off when coolant is above heater-off, default 60.
// RULE_05: cooler stays on for overrun seconds (0 to 240) after cooling.
// RULE_06: canopy fan on above its on limit, off below its off limit.
// RULE_07: ambient fan on above its on limit, off below its off limit.
// RULE_08: each of three channels flags due when hours reach limit.
// RULE_09: an hour limit of zero never flags due.
// RULE_10: each channel flags due when months reach its period.
// RULE_11: a month period of zero never flags due.
// RULE_12: per-channel alarm level 0..3; channel one resets to 3, others 0.
// RULE_13: engine link enable off idles the port; on takes ECU measurements.
// RULE_14: link enabled and ECU communication lost commands engine stop.
// RULE_15: engine maker field 0 to 15, above 11 reserved.
// RULE_16: writing 1 to a channel reset clears its counters.
// RULE_17: between limits each relay holds its previous state.
// RULE_18: a fired channel keeps its alarm raised until its counters reset.
module trm_top #(
   parameter int SEC_CYCLES = trm_pkg::TICK_CYC // cycles per second
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [trm_pkg::AW-1:0] paddr, // apb byte address
   input wire logic [trm_pkg::DW-1:0] pwdata, // apb write data
   output logic [trm_pkg::DW-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // unmapped address
   input wire logic [trm_pkg::TW-1:0] coolant_temp, // local coolant
   input wire logic [trm_pkg::TW-1:0] canopy_temp, // canopy sensor
   input wire logic [trm_pkg::TW-1:0] ambient_temp, // ambient sensor
   input wire logic hour_tick, // engine hour pulse
   input wire logic month_tick, // calendar month pulse
   input wire logic ecu_link_ok, // ecu messages arriving
   input wire logic ecu_vld, // ecu measurement strobe
   input wire logic [trm_pkg::MEAS_W-1:0] ecu_oil, // ecu oil pressure
   input wire logic [trm_pkg::TW-1:0] ecu_temp, // ecu coolant temp
   input wire logic [trm_pkg::MEAS_W-1:0] ecu_rpm, // ecu speed
   output logic cooler_relay, // cooler relay function
   output logic heater_relay, // heater relay function
   output logic canopy_fan, // canopy fan relay
   output logic ambient_fan, // ambient fan relay
   output logic svc_due, // maintenance request lamp
   output logic alarm_shutdown, // a channel raised shutdown
   output logic alarm_loaddump, // a channel raised load dump
   output logic alarm_warning, // a channel raised warning
   output logic engine_stop, // stop on lost ecu link
   output logic ecu_port_en, // engine link port active
   output logic [trm_pkg::MEAS_W-1:0] eng_oil, // gated oil pressure
   output logic [trm_pkg::TW-1:0] eng_temp, // gated coolant temp
   output logic [trm_pkg::MEAS_W-1:0] eng_rpm, // gated speed
   output logic irq // enabled status pending
);
   import trm_pkg::*;
   logic net_en_q;
   logic [BRAND_W-1:0] brand_q;
   logic [TW-1:0] cl_on_q, cl_off_q, ht_on_q, ht_off_q;
   logic [TW-1:0] cf_on_q, cf_off_q, af_on_q, af_off_q;
   logic [TW-1:0] ovr_len_q, ovr_q, ovr_d;
   logic [SW-1:0] sec_q;
   trm_cool_t cs_q, cs_d;
   logic cool_q, heat_q, can_q, amb_q, stop_q;
   logic [IW-1:0] ist_q, ien_q, ev;
   logic [NCH-1:0] due, due_prev_q, svc_clr, hit_cfg, hit_cnt;
   logic [NCH-1:0] is_shut, is_ldump, is_warn;
   logic [DW-1:0] rd_ch [NCH+1];
   logic [DW-1:0] rdata_q;
   logic vld_q;
   // apb handshake: capture read word, then answer
   wire cap = ce & psel & ~vld_q;
   assign pready = ce & vld_q;
   wire acc_done = psel & penable & pready;
   wire wr_en = acc_done & pwrite;
   // address decode
   wire hit_ctrl = paddr == ADDR_CTRL;
   wire hit_clth = paddr == ADDR_CLTH;
   wire hit_fanth = paddr == ADDR_FANTH;
   wire hit_ovr = paddr == ADDR_OVR;
   wire hit_svrst = paddr == ADDR_SVRST;
   wire hit_stat = paddr == ADDR_STAT;
   wire hit_ist = paddr == ADDR_IST;
   wire hit_iclr = paddr == ADDR_ICLR;
   wire hit_ien = paddr == ADDR_IEN;
   wire hit_any = hit_ctrl | hit_clth | hit_fanth | hit_ovr | hit_svrst |
                  hit_stat | hit_ist | hit_iclr | hit_ien |
                  (|hit_cfg) | (|hit_cnt);
   assign pslverr = acc_done & ~hit_any;
   // clipped write fields
   function automatic logic [TW-1:0] clip_t(input logic [TW-1:0] v,
                                            input logic [TW-1:0] m);
      return (v > m) ? m : v;
   endfunction
   wire [TW-1:0] wb0 = clip_t(pwdata[0 +: TW], T_MAX);
   wire [TW-1:0] wb1 = clip_t(pwdata[TW +: TW], T_MAX);
   wire [TW-1:0] wb2 = clip_t(pwdata[2*TW +: TW], T_MAX);
   wire [TW-1:0] wb3 = clip_t(pwdata[3*TW +: TW], T_MAX);
   // temperature source: ecu when the link is enabled
   wire [TW-1:0] cool_t = net_en_q ? eng_temp : coolant_temp; // [RULE_13]
   wire cl_hot = cool_t > cl_on_q;
   wire cl_cold = cool_t < cl_off_q;
   wire sec_tick = sec_q == SW'(SEC_CYCLES - 1);
   wire ovr_start = (cs_q == TRM_CL_ON) && (cs_d == TRM_CL_OVR);
   // read word assembly
   wire [DW-1:0] ctrl_w = DW'({brand_q, 3'h0, net_en_q});
   wire [DW-1:0] stat_w = DW'({net_en_q & ~ecu_link_ok,
                               brand_q > BRAND_MAX, stop_q, svc_due,
                               amb_q, can_q, heat_q, cool_q});
   assign rd_ch[0] = ({DW{hit_ctrl}} & ctrl_w) |
                     ({DW{hit_clth}} & {ht_off_q, ht_on_q, cl_off_q,
                                        cl_on_q}) |
                     ({DW{hit_fanth}} & {af_off_q, af_on_q, cf_off_q,
                                         cf_on_q}) |
                     ({DW{hit_ovr}} & DW'(ovr_len_q)) |
                     ({DW{hit_stat}} & stat_w) |
                     ({DW{hit_ist}} & DW'(ist_q)) |
                     ({DW{hit_ien}} & DW'(ien_q));
   assign svc_due = |due;
   assign alarm_shutdown = |is_shut;
   assign alarm_loaddump = |is_ldump;
   assign alarm_warning = |is_warn;
   // maintenance channels with their config words
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [HW-1:0] hl_q, hc;
      logic [MW-1:0] ml_q, mc;
      trm_alm_t lv_q, alm;
      wire [HW-1:0] w_h = pwdata[SVC_HRS +: HW];
      wire [MW-1:0] w_m = pwdata[SVC_MON +: MW];
      assign hit_cfg[c] = paddr == AW'(ADDR_SVC0 + c * CH_STEP);
      assign hit_cnt[c] = paddr == AW'(ADDR_CNT0 + c * CH_STEP);
      assign svc_clr[c] = wr_en & hit_svrst & pwdata[c]; // [RULE_16]
      assign rd_ch[c+1] = rd_ch[c] |
         ({DW{hit_cfg[c]}} & (DW'(hl_q) << SVC_HRS | DW'(ml_q) << SVC_MON |
                              DW'(lv_q) << SVC_LVL)) |
         ({DW{hit_cnt[c]}} & (DW'(hc) << SVC_HRS | DW'(mc) << SVC_MON));
      assign is_shut[c] = alm == TRM_ALM_SHUT;
      assign is_ldump[c] = alm == TRM_ALM_LDUMP;
      assign is_warn[c] = alm == TRM_ALM_WARN;
      // limits and alarm level, channel one warns by default
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            hl_q <= HRS_RST;
            ml_q <= MON_RST;
            lv_q <= (c == 0) ? TRM_ALM_WARN : TRM_ALM_NONE; // [RULE_12]
         end else if (ce && wr_en && hit_cfg[c]) begin
            hl_q <= (w_h > HRS_MAX) ? HRS_MAX : w_h; // [RULE_08]
            ml_q <= (w_m > MON_MAX) ? MON_MAX : w_m; // [RULE_10]
            lv_q <= trm_alm_t'(pwdata[SVC_LVL +: 2]); // [RULE_12]
         end
      end
      trm_svc u_svc (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .hour_tick(hour_tick),
         .month_tick(month_tick),
         .clr(svc_clr[c]),
         .hrs_lim(hl_q),
         .mon_lim(ml_q),
         .lvl(lv_q),
         .due_q(due[c]),
         .alarm_q(alm),
         .hrs_q(hc),
         .mon_q(mc)
      );
   end
   // interrupt events, set wins over a clear in the same cycle
   assign ev[IRQ_DUE0 +: NCH] = due & ~due_prev_q;
   assign ev[IRQ_STOP] = (net_en_q & ~ecu_link_ok) & ~stop_q;
   assign ev[IRQ_COOL] = (cs_d != TRM_CL_OFF) & ~cool_q;
   wire [IW-1:0] iclr = (wr_en & hit_iclr) ? pwdata[IW-1:0] : '0;
   assign irq = |(ist_q & ien_q);
   // apb read capture and answer flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
         vld_q <= 1'b0;
      end else begin
         if (cap) rdata_q <= rd_ch[NCH];
         if (acc_done) vld_q <= 1'b0;
         else if (cap) vld_q <= 1'b1;
      end
   end
   assign prdata = rdata_q;
   // control and threshold registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         net_en_q <= 1'b0;
         brand_q <= '0;
         {ht_off_q, ht_on_q} <= {HT_OFF_RST, HT_ON_RST};
         {cl_off_q, cl_on_q} <= {CL_OFF_RST, CL_ON_RST};
         {af_off_q, af_on_q} <= {FAN_OFF_RST, FAN_ON_RST};
         {cf_off_q, cf_on_q} <= {FAN_OFF_RST, FAN_ON_RST};
         ovr_len_q <= OVR_RST;
         ien_q <= '0;
      end else if (ce && wr_en) begin
         if (hit_ctrl) begin
            net_en_q <= pwdata[CTRL_NET]; // [RULE_13]
            brand_q <= pwdata[CTRL_BRAND +: BRAND_W]; // [RULE_15]
         end
         if (hit_clth) {ht_off_q, ht_on_q, cl_off_q, cl_on_q} <=
            {wb3, wb2, wb1, wb0};
         if (hit_fanth) {af_off_q, af_on_q, cf_off_q, cf_on_q} <=
            {wb3, wb2, wb1, wb0};
         if (hit_ovr) ovr_len_q <= clip_t(pwdata[TW-1:0], OVR_MAX);
         if (hit_ien) ien_q <= pwdata[IW-1:0];
      end
   end
   // cooler with overrun timer
   always_comb begin
      cs_d = cs_q;
      ovr_d = ovr_q;
      case (cs_q)
         TRM_CL_OFF: begin
            if (cl_hot) cs_d = TRM_CL_ON; // [RULE_01]
         end
         TRM_CL_ON: begin
            if (cl_cold && !cl_hot) begin
               if (ovr_len_q == '0) begin
                  cs_d = TRM_CL_OFF; // [RULE_02]
               end else begin
                  cs_d = TRM_CL_OVR; // [RULE_05]
                  ovr_d = ovr_len_q;
               end
            end
         end
         TRM_CL_OVR: begin
            if (cl_hot) begin
               cs_d = TRM_CL_ON; // [RULE_01]
            end else if (sec_tick) begin
               ovr_d = TW'(ovr_q - 1'b1); // [RULE_05]
               if (ovr_q <= TW'(1)) cs_d = TRM_CL_OFF;
            end
         end
         default: cs_d = TRM_CL_OFF;
      endcase
   end
   // relays, second prescaler, link supervision, interrupt status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_q <= TRM_CL_OFF;
         ovr_q <= '0;
         sec_q <= '0;
         {cool_q, heat_q, can_q, amb_q, stop_q} <= '0;
         {eng_oil, eng_temp, eng_rpm} <= '0;
         due_prev_q <= '0;
         ist_q <= '0;
      end else if (ce) begin
         cs_q <= cs_d;
         ovr_q <= ovr_d;
         sec_q <= (ovr_start || sec_tick) ? '0 : SW'(sec_q + 1'b1);
         cool_q <= cs_d != TRM_CL_OFF; // [RULE_05]
         if (cool_t < ht_on_q) heat_q <= 1'b1; // [RULE_03] [RULE_17]
         else if (cool_t > ht_off_q) heat_q <= 1'b0; // [RULE_04]
         if (canopy_temp > cf_on_q) can_q <= 1'b1; // [RULE_06] [RULE_17]
         else if (canopy_temp < cf_off_q) can_q <= 1'b0; // [RULE_06]
         if (ambient_temp > af_on_q) amb_q <= 1'b1; // [RULE_07] [RULE_17]
         else if (ambient_temp < af_off_q) amb_q <= 1'b0; // [RULE_07]
         stop_q <= net_en_q & ~ecu_link_ok; // [RULE_14]
         if (net_en_q && ecu_vld) begin
            {eng_oil, eng_temp, eng_rpm} <= {ecu_oil, ecu_temp, ecu_rpm};
         end
         due_prev_q <= due;
         ist_q <= (ist_q & ~iclr) | ev;
      end
   end
   assign cooler_relay = cool_q;
   assign heater_relay = heat_q;
   assign canopy_fan = can_q;
   assign ambient_fan = amb_q;
   assign engine_stop = stop_q;
   assign ecu_port_en = net_en_q; // [RULE_13]
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_cool_drop;
      ce && cs_q == TRM_CL_ON && cl_cold && !cl_hot && ovr_len_q != '0;
   endsequence
   cool_on_a: assert property (ce && cl_hot |=> cooler_relay) // [RULE_01]
      else $error("cooler not on above cooler-on");
   cool_off_a: assert property (ce && cl_cold && !cl_hot && // [RULE_02]
      cs_q != TRM_CL_OVR && ovr_len_q == '0 |=> !cooler_relay)
      else $error("cooler not off below cooler-off");
   overrun_a: assert property (s_cool_drop |=> // [RULE_05]
      cooler_relay && ovr_q == $past(ovr_len_q) && sec_q == '0)
      else $error("overrun not started on cooling end");
   heat_on_a: assert property (ce && cool_t < ht_on_q |=> // [RULE_03]
      heater_relay)
      else $error("heater not on below heater-on");
   heat_off_a: assert property (ce && cool_t > ht_off_q && // [RULE_04]
      cool_t >= ht_on_q |=> !heater_relay)
      else $error("heater not off above heater-off");
   canopy_on_a: assert property (ce && canopy_temp > cf_on_q |=> // [RULE_06]
      canopy_fan)
      else $error("canopy fan not on");
   ambient_off_a: assert property (ce && ambient_temp < af_off_q && // [RULE_07]
      ambient_temp <= af_on_q |=> !ambient_fan)
      else $error("ambient fan not off");
   fan_hold_a: assert property (ce && canopy_temp <= cf_on_q && // [RULE_17]
      canopy_temp >= cf_off_q |=> $stable(canopy_fan))
      else $error("canopy fan toggled inside band");
   link_stop_a: assert property (ce && net_en_q && !ecu_link_ok |=> // [RULE_14]
      engine_stop)
      else $error("lost ecu link did not stop engine");
   port_idle_a: assert property (ce && !net_en_q && // [RULE_13]
      !(wr_en && hit_ctrl) |=> $stable(eng_rpm) && $stable(eng_oil) &&
      !ecu_port_en)
      else $error("ecu data taken with link disabled");
   irq_set_a: assert property (ce && ev[IRQ_STOP] |=> ist_q[IRQ_STOP])
      else $error("stop event lost against clear");
endmodule

// ### hw/trm_pkg.sv
// constants, register map and types of the thermal relay service monitor
package trm_pkg;
   // clock and timing
   localparam int CLK_HZ = 10_000_000; // pclk rate, Hz
   localparam int TICK_S = 1; // overrun timer step, seconds
   localparam int TICK_CYC = TICK_S * CLK_HZ; // cycles per step
   localparam int SW = 24; // prescaler width
   // widths and counts
   localparam int TW = 8; // temperature, degrees
   localparam int HW = 13; // engine hours
   localparam int MW = 5; // months
   localparam int AW = 8; // apb byte address
   localparam int DW = 32; // apb data
   localparam int MEAS_W = 16; // oil pressure and speed words
   localparam int NCH = 3; // maintenance channels
   localparam int IW = 5; // interrupt sources
   localparam int BRAND_W = 4;
   // register byte offsets
   localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADDR_CLTH = 8'h04;
   localparam logic [AW-1:0] ADDR_FANTH = 8'h08;
   localparam logic [AW-1:0] ADDR_OVR = 8'h0c;
   localparam logic [AW-1:0] ADDR_SVC0 = 8'h10;
   localparam logic [AW-1:0] ADDR_SVRST = 8'h1c;
   localparam logic [AW-1:0] ADDR_STAT = 8'h20;
   localparam logic [AW-1:0] ADDR_IST = 8'h24;
   localparam logic [AW-1:0] ADDR_ICLR = 8'h28;
   localparam logic [AW-1:0] ADDR_IEN = 8'h2c;
   localparam logic [AW-1:0] ADDR_CNT0 = 8'h30;
   localparam int CH_STEP = 4; // byte step between channel words
   // field positions
   localparam int CTRL_NET = 0;
   localparam int CTRL_BRAND = 4;
   localparam int SVC_HRS = 0;
   localparam int SVC_MON = 16;
   localparam int SVC_LVL = 24;
   // ranges, writes above are clipped except brand, which is stored as written and flagged in status
   localparam logic [TW-1:0] T_MAX = 8'hfa;
   localparam logic [TW-1:0] OVR_MAX = 8'hf0;
   localparam logic [HW-1:0] HRS_MAX = 13'h1388;
   localparam logic [MW-1:0] MON_MAX = 5'h18;
   localparam logic [BRAND_W-1:0] BRAND_MAX = 4'hb;
   // reset values
   localparam logic [TW-1:0] CL_ON_RST = 8'h5a;
   localparam logic [TW-1:0] CL_OFF_RST = 8'h50;
   localparam logic [TW-1:0] HT_ON_RST = 8'h32;
   localparam logic [TW-1:0] HT_OFF_RST = 8'h3c;
   localparam logic [TW-1:0] FAN_ON_RST = 8'h5a;
   localparam logic [TW-1:0] FAN_OFF_RST = 8'h50;
   localparam logic [TW-1:0] OVR_RST = 8'h00;
   localparam logic [HW-1:0] HRS_RST = 13'h00fa;
   localparam logic [MW-1:0] MON_RST = 5'h06;
   // interrupt bit positions
   localparam int IRQ_DUE0 = 0; // one per channel
   localparam int IRQ_STOP = 3;
   localparam int IRQ_COOL = 4;
   typedef enum logic [1:0] {
      TRM_ALM_NONE, TRM_ALM_SHUT, TRM_ALM_LDUMP, TRM_ALM_WARN
   } trm_alm_t;
   typedef enum logic [1:0] {
      TRM_CL_OFF, TRM_CL_ON, TRM_CL_OVR
   } trm_cool_t;
endpackage

// ### hw/trm_svc.sv
// one maintenance channel: hour and month counters, due latch, alarm
`timescale 1ns/10ps
module trm_svc (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic hour_tick, // one engine hour elapsed
   input wire logic month_tick, // one month elapsed
   input wire logic clr, // restart interval
   input wire logic [trm_pkg::HW-1:0] hrs_lim, // hour limit, 0 off
   input wire logic [trm_pkg::MW-1:0] mon_lim, // month limit, 0 off
   input wire trm_pkg::trm_alm_t lvl, // configured alarm level
   output logic due_q, // maintenance due
   output trm_pkg::trm_alm_t alarm_q, // raised alarm level
   output logic [trm_pkg::HW-1:0] hrs_q, // hours since service
   output logic [trm_pkg::MW-1:0] mon_q // months since service
);
   import trm_pkg::*;
   logic [HW-1:0] hrs_d;
   logic [MW-1:0] mon_d;
   logic due_d;
   // limit compare, a zero limit never fires
   wire hrs_hit = (hrs_lim != '0) && (hrs_q >= hrs_lim); // [RULE_08] [RULE_09]
   wire mon_hit = (mon_lim != '0) && (mon_q >= mon_lim); // [RULE_10] [RULE_11]
   // saturating counters, cleared by the reset command
   assign hrs_d = clr ? '0 : (hour_tick && hrs_q != '1) ?
                  HW'(hrs_q + 1'b1) : hrs_q; // [RULE_16]
   assign mon_d = clr ? '0 : (month_tick && mon_q != '1) ?
                  MW'(mon_q + 1'b1) : mon_q; // [RULE_16]
   assign due_d = clr ? 1'b0 : (due_q | hrs_hit | mon_hit); // [RULE_18]
   // state, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hrs_q <= '0;
         mon_q <= '0;
         due_q <= 1'b0;
         alarm_q <= TRM_ALM_NONE;
      end else if (ce) begin
         hrs_q <= hrs_d;
         mon_q <= mon_d;
         due_q <= due_d;
         alarm_q <= due_d ? lvl : TRM_ALM_NONE; // [RULE_18]
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_rst_cmd;
      ce && clr;
   endsequence
   sequence s_fire;
      ce && !clr && !due_q ##1 due_q;
   endsequence
   hrs_due_a: assert property (ce && !clr && hrs_hit |=> due_q) // [RULE_08]
      else $error("hour limit reached without due");
   mon_due_a: assert property (ce && !clr && mon_hit |=> due_q) // [RULE_10]
      else $error("month limit reached without due");
   zero_lim_a: assert property (ce && !clr && hrs_lim == '0 && // [RULE_09]
      mon_lim == '0 && !due_q |=> !due_q)
      else $error("due raised with both limits zero");
   svc_clr_a: assert property (s_rst_cmd |=> hrs_q == '0 && // [RULE_16]
      mon_q == '0 && !due_q && alarm_q == TRM_ALM_NONE)
      else $error("reset command did not restart interval");
   alarm_hold_a: assert property (s_fire |-> // [RULE_18]
      alarm_q == $past(lvl) ##1 (due_q || $past(clr)))
      else $error("alarm not raised or dropped without reset");
endmodule

// ### verif/trm_ecu_model.sv
// behavioural engine control unit sending measurement frames
`timescale 1ns/10ps
module trm_ecu_model #(
   parameter int GAP = 8 // cycles between frames
) (
   input wire logic pclk, // system clock
   input wire logic alive, // unit talking on the link
   input wire logic [7:0] val, // temperature to report
   output logic link_ok, // frames arriving
   output logic vld, // frame strobe
   output logic [15:0] oil, // oil word
   output logic [7:0] temp, // temperature
   output logic [15:0] rpm // speed word
);
   int n = 0;
   logic snd;
   assign snd = alive && n == 0;
   initial {link_ok, vld, oil, temp, rpm} = '0;
   // frame every GAP cycles, data lines churn between frames
   always @(posedge pclk) begin
      n <= (n + 1) % GAP;
      link_ok <= alive;
      vld <= snd;
      oil <= snd ? {8'ha5, val} : ~oil;
      temp <= snd ? val : ~temp;
      rpm <= snd ? {val, 8'h5a} : ~rpm;
   end
endmodule

// ### verif/test_trm_top.sv
// self-checking bench of the thermal relay service monitor
`timescale 1ns/10ps
module test_trm_top;
   import trm_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, alive = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_q;
   logic hour_tick = 1'b0, month_tick = 1'b0, pready, pslverr;
   logic [AW-1:0] paddr = '0;
   logic [DW-1:0] pwdata = '0, prdata, rd_q, rel, alm;
   logic [TW-1:0] coolant_temp = 8'h46, canopy_temp = 8'h46;
   logic [TW-1:0] ambient_temp = 8'h46, ecu_temp, eng_temp;
   logic [15:0] ecu_oil, ecu_rpm, eng_oil, eng_rpm;
   logic ecu_link_ok, ecu_vld, cooler_relay, heater_relay, canopy_fan;
   logic ambient_fan, svc_due, alarm_shutdown, alarm_loaddump;
   logic alarm_warning, engine_stop, ecu_port_en, irq;
   int miscompares = 0;
   int samples_checked = 0;
   logic [7:0] tv [7] = '{8'h5b, 8'h55, 8'h4f, 8'h55, 8'h31, 8'h37, 8'h3d};
   logic [3:0] rv [7] = '{4'hb, 4'hb, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0};
   // grouped views of relay and alarm outputs
   assign rel = {28'h0, cooler_relay, heater_relay, canopy_fan, ambient_fan};
   assign alm = {28'h0, svc_due, alarm_shutdown, alarm_loaddump,
      alarm_warning};
   always #50 pclk = ~pclk;
   trm_top #(.SEC_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coolant_temp(coolant_temp), .canopy_temp(canopy_temp),
      .ambient_temp(ambient_temp), .hour_tick(hour_tick),
      .month_tick(month_tick), .ecu_link_ok(ecu_link_ok), .ecu_vld(ecu_vld),
      .ecu_oil(ecu_oil), .ecu_temp(ecu_temp), .ecu_rpm(ecu_rpm),
      .cooler_relay(cooler_relay), .heater_relay(heater_relay),
      .canopy_fan(canopy_fan), .ambient_fan(ambient_fan), .svc_due(svc_due),
      .alarm_shutdown(alarm_shutdown), .alarm_loaddump(alarm_loaddump),
      .alarm_warning(alarm_warning), .engine_stop(engine_stop),
      .ecu_port_en(ecu_port_en), .eng_oil(eng_oil), .eng_temp(eng_temp),
      .eng_rpm(eng_rpm), .irq(irq));
   trm_ecu_model ecu (.pclk(pclk), .alive(alive), .val(8'h77),
      .link_ok(ecu_link_ok), .vld(ecu_vld), .oil(ecu_oil), .temp(ecu_temp),
      .rpm(ecu_rpm));
   // compare, verdict and bus helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t ns: got %h, want %h", $time, s, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ready is sampled at a rising edge, the answer taken at that edge
      for (n = 0; n < 40; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 40) begin
         miscompares++;
         $display("[FAIL] %0t ns: apb ready timeout", $time);
         print_verdict();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_q, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic pulse(input logic m);
      @(posedge pclk);
      if (m) month_tick <= 1'b1;
      else hour_tick <= 1'b1;
      @(posedge pclk);
      month_tick <= 1'b0;
      hour_tick <= 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ADDR_CLTH, 32'h3c32505a);
      rdc(ADDR_FANTH, 32'h505a505a);
      rdc(ADDR_OVR, 32'h0);
      rdc(ADDR_SVC0, 32'h030600fa);
      rdc(ADDR_SVC0 + 8'h04, 32'h000600fa);
      rdc(ADDR_SVC0 + 8'h08, 32'h000600fa);
      rdc(8'h40, 32'h0);
      chk({err_q, engine_stop}, 32'h2);
      $display("test defaults done");
      for (int i = 0; i < 7; i++) begin
         @(posedge pclk);
         coolant_temp <= tv[i];
         canopy_temp <= tv[i];
         ambient_temp <= tv[i];
         cyc(3);
         chk(rel, rv[i]);
      end
      apb(1'b1, ADDR_OVR, 32'h3);
      coolant_temp <= 8'h5f;
      cyc(3);
      @(posedge pclk);
      coolant_temp <= 8'h46;
      cyc(15);
      chk(rel, 32'h8);
      cyc(30);
      chk(rel, 32'h0);
      // clock enable low freezes the canopy relay
      @(posedge pclk);
      ce <= 1'b0;
      canopy_temp <= 8'h5b;
      cyc(3);
      chk(rel, 32'h0);
      @(posedge pclk);
      ce <= 1'b1;
      cyc(2);
      chk(rel, 32'h2);
      @(posedge pclk);
      canopy_temp <= 8'h3d;
      $display("test relays done");
      apb(1'b1, ADDR_SVC0, 32'h03000002);
      apb(1'b1, ADDR_SVC0 + 8'h04, 32'h01010000);
      apb(1'b1, ADDR_SVC0 + 8'h08, 32'h02000000);
      pulse(1'b0);
      cyc(2);
      chk(alm, 32'h0);
      pulse(1'b0);
      cyc(2);
      chk(alm, 32'h9);
      rdc(ADDR_CNT0, 32'h2);
      apb(1'b1, ADDR_SVRST, 32'h1);
      cyc(2);
      chk(alm, 32'h0);
      rdc(ADDR_CNT0, 32'h0);
      pulse(1'b1);
      cyc(2);
      chk(alm, 32'hc);
      apb(1'b1, ADDR_SVRST, 32'h0);
      cyc(2);
      chk(alm, 32'hc);
      $display("test service done");
      alive <= 1'b1;
      cyc(20);
      chk({eng_temp, ecu_port_en}, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'hc1);
      apb(1'b1, ADDR_IEN, 32'h8);
      cyc(20);
      chk({eng_oil, eng_temp}, 32'ha57777);
      chk({eng_rpm, 15'h0, ecu_port_en}, 32'h775a0001);
      chk(rel, 32'h8);
      rdc(ADDR_STAT, 32'h51);
      alive <= 1'b0;
      cyc(3);
      chk({engine_stop, irq}, 32'h3);
      rdc(ADDR_IST, 32'h1b);
      apb(1'b1, ADDR_IEN, 32'h0);
      cyc(0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_IEN, 32'h8);
      apb(1'b1, ADDR_ICLR, 32'h8);
      cyc(0);
      chk({engine_stop, irq}, 32'h2);
      rdc(ADDR_IST, 32'h13);
      apb(1'b1, ADDR_CLTH, 32'h3c3250ff);
      rdc(ADDR_CLTH, 32'h3c3250fa);
      $display("test link done");
      print_verdict();
   end
endmodule
